// ===== core/gpt_timer.sv
// Purpose: general-purpose timer with prescaler, reload counter and capture/compare channels
// Assumes: configuration ports come from logic on core_clk; pins are asynchronous
// Notes:   widths and channel count select the full, wide or reduced variant
`include "gpt_map.svh"

module gpt_timer #(
    parameter int CNT_W     = 16,
    parameter int NUM_CH    = 4,
    parameter bit UPDOWN_EN = 1'b1
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    // counter control
    input  wire logic                   start,
    input  wire logic                   stop,
    input  wire logic                   one_pulse,
    input  wire gpt_pkg::gpt_cnt_mode_e cnt_mode,
    input  wire gpt_pkg::gpt_src_e      src_sel,
    input  wire logic [15:0]            psc_val,
    input  wire logic [CNT_W-1:0]       reload_val,
    // debug
    input  wire logic                   dbg_halt,
    input  wire logic                   dbg_freeze_en,
    // inter-timer link
    input  wire logic                   trig_in,
    input  wire gpt_pkg::gpt_trg_e      trig_mode,
    output logic                        trig_out,
    // pins
    input  wire logic                   low_speed_crystal_clock,
    input  wire logic                   enc_a,
    input  wire logic                   enc_b,
    input  wire logic [2:0]             hall_in,
    input  wire logic                   hall_en,
    input  wire logic [NUM_CH-1:0]      ch_in,
    // channels
    input  wire gpt_pkg::gpt_ch_mode_e  ch_mode [NUM_CH],
    input  wire logic [CNT_W-1:0]       ch_cmp  [NUM_CH],
    output logic [NUM_CH-1:0]           ch_out,
    output logic [CNT_W-1:0]            ch_cap  [NUM_CH],
    // flags and dma
    input  wire logic                   upd_flag_clr,
    input  wire logic [NUM_CH-1:0]      cc_flag_clr,
    input  wire logic                   dma_upd_en,
    input  wire logic [NUM_CH-1:0]      dma_cc_en,
    output logic                        upd_flag,
    output logic [NUM_CH-1:0]           cc_flag,
    output logic                        dma_upd_req,
    output logic [NUM_CH-1:0]           dma_cc_req,
    output logic [CNT_W-1:0]            cnt_val,
    output logic                        running
);
    import gpt_pkg::*;

    localparam int SYN_W = `GPT_PIN_CH + NUM_CH;

    if (!(CNT_W == 16 || CNT_W == 32)) begin : g_bad_w
        $error("CNT_W must be 16 or 32");
    end
    if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_ch
        $error("NUM_CH must be 1 to 4");
    end

    logic [SYN_W-1:0]     sync_s1_reg;
    logic [SYN_W-1:0]     sync_s2_reg;
    logic [SYN_W-1:0]     pin_prev_reg;
    logic [`GPT_PSC_W-1:0] psc_cnt_reg;
    logic [CNT_W-1:0]     cnt_reg;
    logic [CNT_W-1:0]     cnt_next;
    logic                 dir_down_reg;
    logic                 dir_next;
    logic                 run_reg;
    logic                 trig_prev_reg;
    logic                 trig_out_reg;
    logic                 upd_flag_reg;
    logic                 dma_upd_reg;
    logic [NUM_CH-1:0]    cc_flag_reg;
    logic [NUM_CH-1:0]    dma_cc_reg;
    logic [NUM_CH-1:0]    cap_evt;
    logic [NUM_CH-1:0]    cc_evt;
    logic                 trig_rise;
    logic                 frozen;
    logic                 src_tick;
    logic                 psc_hit;
    logic                 cnt_tick;
    logic                 upd_evt;
    logic                 enc_step;
    logic                 enc_down;
    logic                 hall_chg;
    logic                 want_down;

    // all pins but hall_en pass two flip-flops; logic reads sync_s2_reg and its delayed copy pin_prev_reg
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync_s1_reg  <= '0;
            sync_s2_reg  <= '0;
            pin_prev_reg <= '0;
        end else begin
            sync_s1_reg  <= {ch_in, hall_in, enc_b, enc_a, low_speed_crystal_clock};
            sync_s2_reg  <= sync_s1_reg;
            pin_prev_reg <= sync_s2_reg;
        end
    end

    assign trig_rise = trig_in && !trig_prev_reg;
    assign frozen    = dbg_freeze_en && dbg_halt;
    assign enc_step  = (sync_s2_reg[`GPT_PIN_ENC_A] ^ pin_prev_reg[`GPT_PIN_ENC_A])
                     | (sync_s2_reg[`GPT_PIN_ENC_B] ^ pin_prev_reg[`GPT_PIN_ENC_B]);
    assign enc_down  = pin_prev_reg[`GPT_PIN_ENC_A] ^ sync_s2_reg[`GPT_PIN_ENC_B];
    assign hall_chg  = |(sync_s2_reg[`GPT_PIN_HALL +: `GPT_HALL_W]
                       ^ pin_prev_reg[`GPT_PIN_HALL +: `GPT_HALL_W]);

    always_comb begin
        unique case (src_sel)
            GPT_SRC_CORE: src_tick = 1'b1;
            GPT_SRC_LSCK: src_tick = sync_s2_reg[`GPT_PIN_LSCK]
                                   && !pin_prev_reg[`GPT_PIN_LSCK];
            GPT_SRC_TRIG: src_tick = trig_rise;
            GPT_SRC_ENC:  src_tick = enc_step;
            default:      src_tick = 1'b0;
        endcase
    end

    assign psc_hit  = psc_cnt_reg == psc_val;
    assign cnt_tick = run_reg && !frozen && src_tick && psc_hit;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            psc_cnt_reg <= `GPT_PSC_RST;
        end else if (trig_mode == GPT_TRG_RESET && trig_rise) begin
            psc_cnt_reg <= `GPT_PSC_RST;
        end else if (run_reg && !frozen && src_tick) begin
            psc_cnt_reg <= psc_hit ? `GPT_PSC_RST : psc_cnt_reg + 16'h0001;
        end
    end

    always_comb begin
        want_down = UPDOWN_EN && ((src_sel == GPT_SRC_ENC) ? enc_down
                                                           : (cnt_mode == GPT_CNT_DOWN));
        cnt_next  = cnt_reg;
        dir_next  = dir_down_reg;
        upd_evt   = 1'b0;
        if (trig_mode == GPT_TRG_RESET && trig_rise) begin
            cnt_next = '0;
            dir_next = 1'b0;
        end else if (cnt_tick) begin
            if (UPDOWN_EN && cnt_mode == GPT_CNT_CENTER && src_sel != GPT_SRC_ENC) begin
                if (!dir_down_reg && cnt_reg >= reload_val) begin
                    cnt_next = reload_val - CNT_W'(1);
                    dir_next = 1'b1;
                    upd_evt  = 1'b1;
                end else if (dir_down_reg && cnt_reg == '0) begin
                    cnt_next = CNT_W'(1);
                    dir_next = 1'b0;
                    upd_evt  = 1'b1;
                end else begin
                    cnt_next = dir_down_reg ? cnt_reg - CNT_W'(1) : cnt_reg + CNT_W'(1);
                end
            end else if (want_down) begin
                dir_next = 1'b1;
                upd_evt  = cnt_reg == '0;
                cnt_next = upd_evt ? reload_val : cnt_reg - CNT_W'(1);
            end else begin
                dir_next = 1'b0;
                upd_evt  = cnt_reg >= reload_val;
                cnt_next = upd_evt ? '0 : cnt_reg + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg      <= '0;
            dir_down_reg <= `GPT_DIR_RST;
        end else begin
            cnt_reg      <= cnt_next;
            dir_down_reg <= dir_next;
        end
    end

    // run control: a stop or finished single pulse wins over a start
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            run_reg <= `GPT_RUN_RST;
        end else if (stop || (one_pulse && upd_evt)) begin
            run_reg <= 1'b0;
        end else if (start || (trig_mode == GPT_TRG_START && trig_rise)) begin
            run_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            trig_prev_reg <= 1'b0;
            trig_out_reg  <= 1'b0;
            dma_upd_reg   <= 1'b0;
            dma_cc_reg    <= '0;
        end else begin
            trig_prev_reg <= trig_in;
            trig_out_reg  <= upd_evt;
            dma_upd_reg   <= upd_evt && dma_upd_en;
            dma_cc_reg    <= cc_evt & dma_cc_en;
        end
    end

    // sticky flags: a new event wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            upd_flag_reg <= 1'b0;
            cc_flag_reg  <= '0;
        end else begin
            upd_flag_reg <= upd_evt || (upd_flag_reg && !upd_flag_clr);
            cc_flag_reg  <= cc_evt | (cc_flag_reg & ~cc_flag_clr);
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        if (i == 0) begin : g_cap0
            assign cap_evt[i] = hall_en ? hall_chg
                              : sync_s2_reg[`GPT_PIN_CH] && !pin_prev_reg[`GPT_PIN_CH];
        end else begin : g_capn
            assign cap_evt[i] = sync_s2_reg[`GPT_PIN_CH + i] && !pin_prev_reg[`GPT_PIN_CH + i];
        end
        gpt_channel #(
            .CNT_W (CNT_W)
        ) u_ch (
            .core_clk (core_clk),
            .resetn   (resetn),
            .mode     (ch_mode[i]),
            .cmp_val  (ch_cmp[i]),
            .cnt      (cnt_reg),
            .cnt_next (cnt_next),
            .cnt_tick (cnt_tick),
            .cap_evt  (cap_evt[i]),
            .ch_out   (ch_out[i]),
            .cap_val  (ch_cap[i]),
            .cc_evt   (cc_evt[i])
        );
    end

    assign trig_out    = trig_out_reg;
    assign upd_flag    = upd_flag_reg;
    assign cc_flag     = cc_flag_reg;
    assign dma_upd_req = dma_upd_reg;
    assign dma_cc_req  = dma_cc_reg;
    assign cnt_val     = cnt_reg;
    assign running     = run_reg;

    property p_up_wrap;
        @(posedge core_clk) disable iff (!resetn)
        cnt_tick && !want_down && cnt_mode != GPT_CNT_CENTER && cnt_reg == reload_val
        && !(trig_mode == GPT_TRG_RESET && trig_rise) |=> cnt_val == '0 ##0 upd_flag;
    endproperty
    a_up_wrap: assert property (p_up_wrap) else $error("up wrap failed");

    property p_down_wrap;
        @(posedge core_clk) disable iff (!resetn)
        cnt_tick && want_down && cnt_mode != GPT_CNT_CENTER && cnt_reg == '0
        && !(trig_mode == GPT_TRG_RESET && trig_rise) |=> cnt_val == $past(reload_val);
    endproperty
    a_down_wrap: assert property (p_down_wrap) else $error("down reload failed");

    property p_freeze;
        @(posedge core_clk) disable iff (!resetn)
        frozen && !(trig_mode == GPT_TRG_RESET && trig_rise) |=> $stable(cnt_val);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter moved while frozen");

    property p_psc_step;
        @(posedge core_clk) disable iff (!resetn)
        run_reg && !frozen && src_tick && !psc_hit && trig_mode != GPT_TRG_RESET
        |=> psc_cnt_reg == $past(psc_cnt_reg) + 16'h0001 ##0 $stable(cnt_val);
    endproperty
    a_psc_step: assert property (p_psc_step) else $error("prescaler step wrong");

    property p_one_pulse;
        @(posedge core_clk) disable iff (!resetn)
        one_pulse && upd_evt |=> !running ##1 !running || $past(start) || $past(trig_rise);
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("one pulse kept running");

    property p_dma_upd;
        @(posedge core_clk) disable iff (!resetn)
        upd_evt |=> dma_upd_req == $past(dma_upd_en) ##0 trig_out
                    ##1 !trig_out || $past(upd_evt);
    endproperty
    a_dma_upd: assert property (p_dma_upd) else $error("update dma or trigger wrong");

    property p_flag_set_wins;
        @(posedge core_clk) disable iff (!resetn)
        upd_evt && upd_flag_clr |=> upd_flag;
    endproperty
    a_flag_set_wins: assert property (p_flag_set_wins) else $error("update event lost");

    property p_up_only;
        @(posedge core_clk) disable iff (!resetn)
        !UPDOWN_EN && cnt_tick && cnt_reg < reload_val
        && !(trig_mode == GPT_TRG_RESET && trig_rise)
        |=> cnt_val == $past(cnt_reg) + CNT_W'(1);
    endproperty
    a_up_only: assert property (p_up_only) else $error("up-only counter misstepped");

    c_update:   cover property (@(posedge core_clk) disable iff (!resetn) upd_evt);
    c_center:   cover property (@(posedge core_clk) disable iff (!resetn)
        cnt_mode == GPT_CNT_CENTER && upd_evt && dir_down_reg);
    c_encoder:  cover property (@(posedge core_clk) disable iff (!resetn)
        src_sel == GPT_SRC_ENC && cnt_tick && want_down);
    c_freeze:   cover property (@(posedge core_clk) disable iff (!resetn) frozen && src_tick);

endmodule : gpt_timer

// ===== core/gpt_map.svh
// Purpose: constants of the general-purpose timer (widths, reset values, pin vector layout)
// Assumes: included by bare name from the timer design files
// Notes:   definitions only
`ifndef GPT_MAP_SVH
`define GPT_MAP_SVH

// prescaler width: factor is value plus one, 1 to 65536
`define GPT_PSC_W        16
`define GPT_PSC_RST      16'h0000
// number of hall-effect sensor inputs
`define GPT_HALL_W       3
// position of the fixed pins inside the synchroniser vector
`define GPT_PIN_LSCK     0
`define GPT_PIN_ENC_A    1
`define GPT_PIN_ENC_B    2
`define GPT_PIN_HALL     3
`define GPT_PIN_CH       6
// direction and run state after reset
`define GPT_DIR_RST      1'b0
`define GPT_RUN_RST      1'b0

`endif

// ===== core/gpt_pkg.sv
// Purpose: types shared by the timer and its channel slices
// Assumes: nothing
// Notes:   all state codes are one-hot
package gpt_pkg;

    typedef enum logic [2:0] {
        GPT_CNT_UP     = 3'b001,
        GPT_CNT_DOWN   = 3'b010,
        GPT_CNT_CENTER = 3'b100
    } gpt_cnt_mode_e;

    typedef enum logic [3:0] {
        GPT_SRC_CORE = 4'b0001,
        GPT_SRC_LSCK = 4'b0010,
        GPT_SRC_TRIG = 4'b0100,
        GPT_SRC_ENC  = 4'b1000
    } gpt_src_e;

    typedef enum logic [2:0] {
        GPT_TRG_NONE  = 3'b001,
        GPT_TRG_START = 3'b010,
        GPT_TRG_RESET = 3'b100
    } gpt_trg_e;

    typedef enum logic [2:0] {
        GPT_CH_CAPTURE = 3'b001,
        GPT_CH_COMPARE = 3'b010,
        GPT_CH_PWM     = 3'b100
    } gpt_ch_mode_e;

endpackage : gpt_pkg

// ===== core/gpt_channel.sv
// Purpose: one capture/compare/PWM channel slice of the timer
// Assumes: cap_evt is a one-cycle pulse on core_clk, counter values on the same clock
// Notes:   output and captured value come from flip-flops
module gpt_channel #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    // configuration
    input  wire gpt_pkg::gpt_ch_mode_e mode,
    input  wire logic [CNT_W-1:0]      cmp_val,
    // counter view
    input  wire logic [CNT_W-1:0]      cnt,
    input  wire logic [CNT_W-1:0]      cnt_next,
    input  wire logic                  cnt_tick,
    input  wire logic                  cap_evt,
    // results
    output logic                       ch_out,
    output logic [CNT_W-1:0]           cap_val,
    output logic                       cc_evt
);
    import gpt_pkg::*;

    logic             out_reg;
    logic [CNT_W-1:0] cap_reg;

    always_comb begin
        unique case (mode)
            GPT_CH_CAPTURE: cc_evt = cap_evt;
            default:        cc_evt = cnt_tick && (cnt_next == cmp_val);
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            out_reg <= 1'b0;
        end else begin
            unique case (mode)
                GPT_CH_CAPTURE: out_reg <= 1'b0;
                GPT_CH_COMPARE: out_reg <= cc_evt ? ~out_reg : out_reg;
                default:        out_reg <= (cnt < cmp_val);
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cap_reg <= '0;
        end else if (mode == GPT_CH_CAPTURE && cap_evt) begin
            cap_reg <= cnt;
        end
    end

    assign ch_out  = out_reg;
    assign cap_val = cap_reg;

    property p_pwm_level;
        @(posedge core_clk) disable iff (!resetn)
        mode == GPT_CH_PWM |=> ch_out == ($past(cnt) < $past(cmp_val));
    endproperty
    a_pwm_level: assert property (p_pwm_level) else $error("pwm level wrong");

    property p_capture;
        @(posedge core_clk) disable iff (!resetn)
        mode == GPT_CH_CAPTURE && cap_evt |=> cap_val == $past(cnt);
    endproperty
    a_capture: assert property (p_capture) else $error("capture value lost");

    c_compare_toggle: cover property (@(posedge core_clk) disable iff (!resetn)
        mode == GPT_CH_COMPARE && cc_evt);

endmodule : gpt_channel

// ===== bench/gpt_timer_test.sv
// Purpose: self-checking bench for the general-purpose timer, full 16-bit four-channel variant
// Assumes: inputs change at the falling edge of core_clk; pins toggle slowly against the clock
// Notes:   each scenario restarts from reset
module gpt_timer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import gpt_pkg::*;

    logic           core_clk, resetn, start, stop, one_pulse, dbg_halt, dbg_freeze_en;
    gpt_cnt_mode_e  cnt_mode;
    gpt_src_e       src_sel;
    gpt_trg_e       trig_mode;
    logic [15:0]    psc_val, reload_val, cnt_val;
    logic           trig_in, trig_out, low_speed_crystal_clock, upd_flag_clr, dma_upd_en;
    logic           upd_flag, dma_upd_req, running, enc_a, enc_b, hall_en;
    logic [2:0]     hall_in;
    gpt_ch_mode_e   ch_mode [4];
    logic [15:0]    ch_cmp [4];
    logic [15:0]    ch_cap [4];
    logic [3:0]     ch_in, ch_out, cc_flag_clr, dma_cc_en, cc_flag, dma_cc_req;
    int             err_count;
    int             n_compared;

    gpt_timer dut_u (
        .core_clk, .resetn, .start, .stop, .one_pulse, .cnt_mode, .src_sel, .psc_val,
        .reload_val, .dbg_halt, .dbg_freeze_en, .trig_in, .trig_mode, .trig_out,
        .low_speed_crystal_clock, .enc_a, .enc_b, .hall_in,
        .hall_en, .ch_in, .ch_mode, .ch_cmp, .ch_out, .ch_cap, .upd_flag_clr,
        .cc_flag_clr, .dma_upd_en, .dma_cc_en, .upd_flag, .cc_flag, .dma_upd_req,
        .dma_cc_req, .cnt_val, .running
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        $display("compared %0d, mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic set_idle();
        {start, stop, one_pulse, dbg_halt, dbg_freeze_en, trig_in} = 6'h00;
        {low_speed_crystal_clock, upd_flag_clr, dma_upd_en} = 3'h0;
        {ch_in, cc_flag_clr, dma_cc_en} = 12'h000;
        {enc_a, enc_b, hall_en, hall_in} = 6'h00;
        cnt_mode   = GPT_CNT_UP;
        src_sel    = GPT_SRC_CORE;
        trig_mode  = GPT_TRG_NONE;
        psc_val    = 16'h0000;
        reload_val = 16'hFFFF;
        for (int i = 0; i < 4; i++) begin
            ch_mode[i] = GPT_CH_CAPTURE;
            ch_cmp[i]  = 16'h0000;
        end
    endtask : set_idle

    // reset held ten cycles, then the counter is configured and started
    task automatic go(input gpt_cnt_mode_e m, input logic [15:0] psc, input logic [15:0] rl);
        @(negedge core_clk);
        resetn = 1'b0;
        set_idle();
        repeat (10) @(negedge core_clk);
        resetn     = 1'b1;
        cnt_mode   = m;
        psc_val    = psc;
        reload_val = rl;
        start      = 1'b1;
        @(negedge core_clk);
        start = 1'b0;
    endtask : go

    task automatic wait_cnt(input logic [15:0] v);
        for (int i = 0; i < 300 && cnt_val !== v; i++) @(negedge core_clk);
        check(cnt_val, v, "counter value reached");
    endtask : wait_cnt

    // six successive counter values and the sticky update flag, prescaler off
    task automatic count_seq(input gpt_cnt_mode_e m, input logic [15:0] e [6],
                             input logic [5:0] u);
        go(m, 16'h0000, 16'h0003);
        wait_cnt(e[0]);
        check(upd_flag, u[0], "update flag");
        for (int i = 1; i < 6; i++) begin
            @(negedge core_clk);
            check(cnt_val, e[i], "counter step");
            check(upd_flag, u[i], "update flag");
        end
    endtask : count_seq

    task automatic prescale_walk();
        logic [15:0] v;
        go(GPT_CNT_UP, 16'h0001, 16'h0002);
        dma_upd_en = 1'b1;
        wait_cnt(16'h0001);
        @(negedge core_clk);
        check(cnt_val, 16'h0001, "count held by prescaler");
        @(negedge core_clk);
        check(cnt_val, 16'h0002, "count after two cycles");
        @(negedge core_clk);
        check(cnt_val, 16'h0002, "count held by prescaler");
        @(negedge core_clk);
        check(cnt_val, 16'h0000, "wrap at reload");
        check(upd_flag, 1'b1, "update flag on wrap");
        check(trig_out, 1'b1, "trigger out on update");
        check(dma_upd_req, 1'b1, "update request");
        upd_flag_clr = 1'b1;
        @(negedge core_clk);
        upd_flag_clr = 1'b0;
        check(trig_out, 1'b0, "trigger out one cycle");
        check(dma_upd_req, 1'b0, "update request one cycle");
        check(upd_flag, 1'b0, "update flag cleared");
        stop = 1'b1;
        @(negedge core_clk);
        stop = 1'b0;
        check(running, 1'b0, "stopped");
        v = cnt_val;
        repeat (4) @(negedge core_clk);
        check(cnt_val, v, "counter held while stopped");
    endtask : prescale_walk

    task automatic single_period();
        go(GPT_CNT_UP, 16'h0000, 16'h0002);
        {one_pulse, upd_flag_clr} = 2'b11;
        wait_cnt(16'h0002);
        @(negedge core_clk);
        check(running, 1'b0, "one period then stop");
        check(upd_flag, 1'b1, "event wins over clear");
        repeat (3) @(negedge core_clk);
        check(cnt_val, 16'h0000, "counter stays after one period");
    endtask : single_period

    task automatic debug_freeze();
        go(GPT_CNT_UP, 16'h0000, 16'h00FF);
        wait_cnt(16'h0005);
        dbg_halt      = 1'b1;
        dbg_freeze_en = 1'b1;
        repeat (4) @(negedge core_clk);
        check(cnt_val, 16'h0005, "frozen in halt");
        dbg_freeze_en = 1'b0;
        @(negedge core_clk);
        check(cnt_val, 16'h0006, "halt without freeze counts");
    endtask : debug_freeze

    task automatic channels();
        logic [15:0] prev;
        logic        t0;
        logic        tog;
        logic        dr;
        go(GPT_CNT_UP, 16'h0000, 16'h0007);
        ch_mode[0]   = GPT_CH_PWM;
        ch_cmp[0]    = 16'h0003;
        ch_mode[1]   = GPT_CH_COMPARE;
        ch_cmp[1]    = 16'h0005;
        dma_cc_en[1] = 1'b1;
        for (int i = 0; i < 16; i++) begin
            prev = cnt_val;
            @(negedge core_clk);
            check(ch_out[0], prev < 16'h0003, "pwm level");
        end
        wait_cnt(16'h0004);
        t0  = ch_out[1];
        tog = 1'b0;
        dr  = 1'b0;
        repeat (3) begin
            @(negedge core_clk);
            tog |= (ch_out[1] !== t0);
            dr  |= (dma_cc_req[1] === 1'b1);
        end
        check(tog, 1'b1, "compare toggles output");
        check(dr, 1'b1, "compare request");
        check(cc_flag[1], 1'b1, "compare flag");
    endtask : channels

    task automatic capture();
        logic dr;
        go(GPT_CNT_UP, 16'h0000, 16'hFFFF);
        dma_cc_en[2] = 1'b1;
        repeat (20) @(negedge core_clk);
        ch_in[2] = 1'b1;
        dr       = 1'b0;
        for (int i = 0; i < 8 && cc_flag[2] !== 1'b1; i++) @(negedge core_clk);
        check(ch_cap[2], 16'h0016, "captured count");
        repeat (2) begin
            dr |= (dma_cc_req[2] === 1'b1);
            @(negedge core_clk);
        end
        check(dr, 1'b1, "capture request");
        check(cc_flag[3], 1'b0, "idle channel flag");
        cc_flag_clr[2] = 1'b1;
        @(negedge core_clk);
        cc_flag_clr[2] = 1'b0;
        check(cc_flag[2], 1'b0, "capture flag cleared");
    endtask : capture

    task automatic trig_link();
        logic hit;
        go(GPT_CNT_UP, 16'h0000, 16'hFFFF);
        stop = 1'b1;
        @(negedge core_clk);
        stop      = 1'b0;
        trig_mode = GPT_TRG_START;
        trig_in   = 1'b1;
        repeat (4) @(negedge core_clk);
        check(running, 1'b1, "started by trigger");
        trig_in = 1'b0;
        wait_cnt(16'h0014);
        trig_mode = GPT_TRG_RESET;
        trig_in   = 1'b1;
        hit       = 1'b0;
        repeat (3) begin
            @(negedge core_clk);
            hit |= (cnt_val < 16'h0003);
        end
        check(hit, 1'b1, "counter reset by trigger");
    endtask : trig_link

    // four rising edges of the chosen source advance the counter by four
    task automatic src_count(input gpt_src_e s);
        go(GPT_CNT_UP, 16'h0000, 16'hFFFF);
        src_sel = s;
        repeat (4) begin
            if (s == GPT_SRC_TRIG) trig_in = 1'b1;
            else low_speed_crystal_clock = 1'b1;
            repeat (4) @(negedge core_clk);
            trig_in                 = 1'b0;
            low_speed_crystal_clock = 1'b0;
            repeat (4) @(negedge core_clk);
        end
        check(cnt_val, 16'h0004, "source edges counted");
    endtask : src_count

    // four quadrature steps forward and two back, then a hall change captures on channel 0
    task automatic encoder_hall();
        logic [1:0] seq [6];
        seq = '{2'b10, 2'b11, 2'b01, 2'b00, 2'b01, 2'b11};
        go(GPT_CNT_UP, 16'h0000, 16'hFFFF);
        src_sel = GPT_SRC_ENC;
        for (int i = 0; i < 6; i++) begin
            {enc_a, enc_b} = seq[i];
            repeat (4) @(negedge core_clk);
        end
        check(cnt_val, 16'h0002, "encoder position");
        hall_en = 1'b1;
        hall_in = 3'h1;
        repeat (4) @(negedge core_clk);
        check(cc_flag[0], 1'b1, "hall change flag");
        check(ch_cap[0], 16'h0002, "hall capture value");
    endtask : encoder_hall

    initial begin
        repeat (50000) @(posedge core_clk);
        err_count++;
        stop_test();
    end

    initial begin
        err_count  = 0;
        n_compared = 0;
        resetn     = 1'b0;
        set_idle();
        count_seq(GPT_CNT_UP, '{1, 2, 3, 0, 1, 2}, 6'b111000);
        count_seq(GPT_CNT_DOWN, '{3, 2, 1, 0, 3, 2}, 6'b111111);
        count_seq(GPT_CNT_CENTER, '{1, 2, 3, 2, 1, 0}, 6'b111000);
        prescale_walk();
        single_period();
        debug_freeze();
        channels();
        capture();
        trig_link();
        src_count(GPT_SRC_LSCK);
        src_count(GPT_SRC_TRIG);
        encoder_hall();
        stop_test();
    end
endmodule : gpt_timer_test
